// file: verilog/rorrt_pkg.sv
// rorrt_pkg: constants for the channel off-ramp, restart hold and retry timing block
// assumes a 100 MHz core clock and a command register port with byte-wide codes and up to two data bytes
package rorrt_pkg;
    // ==========================================
    // command codes
    localparam logic [7:0] CMD_OUT_OV = 8'h41;
    localparam logic [7:0] CMD_OUT_UV = 8'h45;
    localparam logic [7:0] CMD_IN_OV = 8'h56;
    localparam logic [7:0] CMD_RISE_TO = 8'h63;
    localparam logic [7:0] CMD_RETRY = 8'hdb;
    localparam logic [7:0] CMD_RESTART = 8'hdc;
    localparam logic [7:0] CMD_OFF_RAMP = 8'he0;
    localparam logic [7:0] CMD_OFF_WARN = 8'he1;
    localparam logic [7:0] CMD_CHAN_CFG = 8'he2;
    localparam logic [7:0] CMD_STATUS = 8'he3;
    // ==========================================
    // reset values
    localparam logic [7:0] RST_OUT_OV = 8'h7a;
    localparam logic [7:0] RST_OUT_UV = 8'hb8;
    localparam logic [7:0] RST_IN_OV = 8'hb8;
    localparam logic [7:0] RST_RISE_TO = 8'hb8;
    localparam logic [15:0] RST_RETRY = 16'hf3e8;
    localparam logic [15:0] RST_RESTART = 16'hfa58;
    localparam logic [15:0] RST_OFF_RAMP = 16'hc300;
    localparam logic [15:0] RST_OFF_WARN = 16'h8000;
    localparam logic [1:0] RST_CHAN_CFG = 2'h0;
    // ==========================================
    // fault byte fields
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam logic [1:0] RESP_BAD = 2'h3;
    localparam logic [2:0] RETRY_ALWAYS = 3'h7;
    localparam int CFG_RETRY_NODECAY = 0;
    localparam int CFG_DECAY_CHECK = 1;
    // ==========================================
    // timing: 100 MHz clock, 1 ms = 100000 cycles
    localparam int CLK_MHZ = 100;
    localparam int US_PER_MS = 1000;
    localparam int CYC_PER_MS = CLK_MHZ * US_PER_MS;
    localparam int MIN_RAMP_US = 250;
    localparam int MIN_RAMP_CYC = MIN_RAMP_US * CLK_MHZ;
    localparam int MAX_RAMP_MS = 1300;
    localparam int DAC_W = 12;
    localparam int MS_W = 20;
    // status bits
    localparam int ST_NONE_ABOVE = 0;
    localparam int ST_INPUT = 1;
    localparam int ST_IN_OV = 2;
    localparam int ST_OFF_WARN = 3;
    localparam int ST_COMM = 4;
    // fixed-point decode: value in ms scaled by 2^8
    localparam int FRAC = 8;
    // ==========================================
    // sequencer states
    typedef enum logic [5:0] {
        RORRT_RUN = 6'h01,
        RORRT_OFF_DLY = 6'h02,
        RORRT_RAMP = 6'h04,
        RORRT_DECAY = 6'h08,
        RORRT_HOLD = 6'h10,
        RORRT_RETRY = 6'h20
    } rorrt_state_t;
endpackage : rorrt_pkg

// file: verilog/rorrt_core.sv
// rorrt_core: off ramp, off-decay warning, restart hold and fault retry for one channel
// assumes a command port driven by a serial bus front end on clk_in; pins synchronised here
// Function
// - after off delay, ramp dac to zero, three-state
// - ramp shorter than 0.25ms becomes 0.25ms
// - ramp at most 1.3s, max value slowest
// - conduction mode kept during ramp
// - warn when decay exceeds off warning limit, only with decay check bit set
// - output off below one eighth of setpoint
// - zero warning limit disables the warning
// - run falling edge: hold run low, then start
// - decay check bit extends hold until off
// - retry interval timed from fault detection
// - retry waits for decay unless config bit 0
// - input overvoltage sets status bits and alert
// - fault bytes one byte, timing two bytes
// - retry interval at 0xdb, default 250ms
// - rise timeout action at 0x63, default 0xb8
// - output overvoltage action at 0x41, default 0x7a
// - output undervoltage action at 0x45, default 0xb8
// - restart hold at 0xdc, default 300ms
// - fault byte: response, retry policy, deglitch
// - wait turn-off delay before ramp
// - bad fault byte: comm fault, write dropped
`timescale 1ns/1ps
`default_nettype none
module rorrt_core
    import rorrt_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS // cycles per millisecond, shorten for simulation
) (
    input wire logic clk_in, // core clock
    input wire logic resetn_in, // async reset, active low
    input wire logic cmd_wr_in, // command write strobe
    input wire logic cmd_word_in, // write carries two data bytes
    input wire logic [7:0] cmd_code_in, // command code
    input wire logic [15:0] cmd_data_in, // write data
    output logic [15:0] cmd_rdata_out, // read data for cmd_code_in
    input wire logic stop_in, // stop condition from run/operation logic
    input wire logic [15:0] off_delay_in, // turn-off delay word
    input wire logic fault_in, // channel fault detected pulse
    input wire logic in_ov_in, // input overvoltage fault pulse
    input wire logic alert_mask_in, // masks alert
    input wire logic [DAC_W-1:0] vset_in, // programmed setpoint
    input wire logic [DAC_W-1:0] vmeas_in, // measured output, same scale
    input wire logic run_pin_in, // run pin level
    output logic run_pin_oe_out, // drives run pin low while high
    output logic run_pin_out, // run pin drive value
    output logic start_out, // start-up request pulse
    output logic [DAC_W-1:0] dac_out, // setpoint dac
    output logic stage_tristate_out, // output stage three-state
    output logic alert_out, // alert, active high
    output logic [4:0] status_out, // status bits
    output logic [7:0] ov_act_out, // output overvoltage action
    output logic [7:0] uv_act_out, // output undervoltage action
    output logic [7:0] rise_act_out // rise timeout action
);
    // ==========================================
    // registers
    logic [7:0] out_ov_q, out_uv_q, in_ov_q, rise_q; // fault action bytes
    logic [15:0] retry_q, restart_q, ramp_q, warn_q; // timing words
    logic [1:0] cfg_q; // channel configuration
    logic [4:0] st_q; // status
    rorrt_state_t state_q; // sequencer state
    logic [31:0] tmr_q; // cycle timer
    logic [MS_W+FRAC-1:0] ms_q; // elapsed ms, scaled
    logic [1:0] run_sync_q; // run pin synchroniser
    logic run_prev_q; // delayed synchronised run
    logic bad_byte; // rejected fault byte
    logic is_off; // output decayed
    logic ms_tick; // one millisecond elapsed

    // linear word to ms scaled by 2^FRAC, negatives clamp to zero
    function automatic logic [MS_W+FRAC-1:0] lin_ms(input logic [15:0] w);
        logic signed [4:0] e;
        logic signed [10:0] m;
        logic [63:0] v;
        e = w[15:11];
        m = w[10:0];
        v = 64'h0;
        if (m > 0) begin
            v = 64'(m) << FRAC;
            if (e < 0) v = v >> (-e);
            else v = v << e;
        end
        if (v > 64'((1 << (MS_W + FRAC)) - 1)) v = 64'((1 << (MS_W + FRAC)) - 1);
        return v[MS_W+FRAC-1:0];
    endfunction : lin_ms

    // ==========================================
    // command writes
    always_comb begin
        bad_byte = 1'b0;
        if (cmd_data_in[RESP_HI:RESP_LO] == RESP_BAD) bad_byte = 1'b1;
        if (cmd_word_in) bad_byte = 1'b1;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            out_ov_q <= RST_OUT_OV;
            out_uv_q <= RST_OUT_UV;
            in_ov_q <= RST_IN_OV;
            rise_q <= RST_RISE_TO;
            retry_q <= RST_RETRY;
            restart_q <= RST_RESTART;
            ramp_q <= RST_OFF_RAMP;
            warn_q <= RST_OFF_WARN;
            cfg_q <= RST_CHAN_CFG;
        end else if (cmd_wr_in) begin
            unique case (cmd_code_in)
                CMD_OUT_OV: if (!bad_byte) out_ov_q <= cmd_data_in[7:0];
                CMD_OUT_UV: if (!bad_byte) out_uv_q <= cmd_data_in[7:0];
                CMD_IN_OV: if (!bad_byte) in_ov_q <= cmd_data_in[7:0];
                CMD_RISE_TO: if (!bad_byte) rise_q <= cmd_data_in[7:0];
                CMD_RETRY: if (cmd_word_in) retry_q <= cmd_data_in;
                CMD_RESTART: if (cmd_word_in) restart_q <= cmd_data_in;
                CMD_OFF_RAMP: if (cmd_word_in) ramp_q <= cmd_data_in;
                CMD_OFF_WARN: if (cmd_word_in) warn_q <= cmd_data_in;
                CMD_CHAN_CFG: cfg_q <= cmd_data_in[1:0];
                default: ;
            endcase
        end
    end

    // read mux
    always_comb begin
        unique case (cmd_code_in)
            CMD_OUT_OV: cmd_rdata_out = {8'h00, out_ov_q};
            CMD_OUT_UV: cmd_rdata_out = {8'h00, out_uv_q};
            CMD_IN_OV: cmd_rdata_out = {8'h00, in_ov_q};
            CMD_RISE_TO: cmd_rdata_out = {8'h00, rise_q};
            CMD_RETRY: cmd_rdata_out = retry_q;
            CMD_RESTART: cmd_rdata_out = restart_q;
            CMD_OFF_RAMP: cmd_rdata_out = ramp_q;
            CMD_OFF_WARN: cmd_rdata_out = warn_q;
            CMD_CHAN_CFG: cmd_rdata_out = {14'h0000, cfg_q};
            CMD_STATUS: cmd_rdata_out = {11'h000, st_q};
            default: cmd_rdata_out = 16'h0000;
        endcase
    end

    assign ov_act_out = out_ov_q;
    assign uv_act_out = out_uv_q;
    assign rise_act_out = rise_q;

    // ==========================================
    // run pin synchroniser and edge
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            run_sync_q <= 2'b11;
            run_prev_q <= 1'b1;
        end else begin
            run_sync_q <= {run_sync_q[0], run_pin_in};
            run_prev_q <= run_sync_q[1];
        end
    end

    // output is off below one eighth of setpoint
    assign is_off = ({3'b000, vmeas_in} << 3) < {3'b000, vset_in};

    // ==========================================
    // state seen one edge ago, marks the first cycle of every state
    rorrt_state_t seen_q; // previous state
    logic state_new; // first cycle in state_q
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) seen_q <= RORRT_RUN;
        else seen_q <= state_q;
    end
    assign state_new = (state_q != seen_q);

    // ==========================================
    // millisecond base and elapsed time
    assign ms_tick = (tmr_q >= 32'(CYC_MS - 1));
    // fraction of the running millisecond, so sub-millisecond ramps keep their length
    logic [MS_W+FRAC-1:0] ms_frac; // scaled part of a millisecond
    assign ms_frac = (MS_W+FRAC)'((tmr_q << FRAC) / 32'(CYC_MS));
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tmr_q <= 32'h0;
            ms_q <= '0;
        end else if (state_q == RORRT_RUN) begin
            tmr_q <= 32'h0;
            ms_q <= '0;
        end else if (state_new) begin
            // each state times from its own entry; the entry cycle counts as the first
            tmr_q <= 32'h1;
            ms_q <= '0;
        end else if (ms_tick) begin
            tmr_q <= 32'h0;
            ms_q <= ms_q + (MS_W+FRAC)'(1 << FRAC);
        end else begin
            tmr_q <= tmr_q + 32'h1;
        end
    end

    // ==========================================
    // sequencer
    logic [MS_W+FRAC-1:0] ramp_ms, ramp_min, ramp_max; // ramp length
    assign ramp_min = (MS_W+FRAC)'((MIN_RAMP_US << FRAC) / US_PER_MS);
    assign ramp_max = (MS_W+FRAC)'(MAX_RAMP_MS << FRAC);
    always_comb begin
        ramp_ms = lin_ms(ramp_q);
        if (ramp_ms < ramp_min) ramp_ms = ramp_min;
        if (ramp_ms > ramp_max) ramp_ms = ramp_max;
    end
    logic retry_fault; // fault response asks for retry
    assign retry_fault = fault_in && (out_ov_q[RETRY_HI:RETRY_LO] == RETRY_ALWAYS);
    logic [MS_W+FRAC-1:0] elapsed; // elapsed ms in state, scaled
    // zero in the entry cycle, so a stale count from the last state never ends this one
    assign elapsed = state_new ? '0 : ms_q + ms_frac;
    logic ramp_done;
    assign ramp_done = elapsed >= ramp_ms;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= RORRT_RUN;
            start_out <= 1'b0;
        end else begin
            start_out <= 1'b0;
            unique case (state_q)
                RORRT_RUN: begin
                    if (retry_fault) state_q <= RORRT_RETRY;
                    else if (run_prev_q && !run_sync_q[1]) state_q <= RORRT_HOLD;
                    else if (stop_in) state_q <= RORRT_OFF_DLY;
                end
                RORRT_OFF_DLY: if (elapsed >= lin_ms(off_delay_in)) state_q <= RORRT_RAMP;
                RORRT_RAMP: if (ramp_done) state_q <= RORRT_DECAY;
                RORRT_DECAY: if (!stop_in) state_q <= RORRT_RUN;
                RORRT_HOLD: begin
                    if (elapsed >= lin_ms(restart_q) && (!cfg_q[CFG_DECAY_CHECK] || is_off)) begin
                        state_q <= RORRT_RUN;
                        start_out <= 1'b1;
                    end
                end
                RORRT_RETRY: begin
                    if (elapsed >= lin_ms(retry_q) && (cfg_q[CFG_RETRY_NODECAY] || is_off)) begin
                        state_q <= RORRT_RUN;
                        start_out <= 1'b1;
                    end
                end
            endcase
        end
    end

    // dac ramp: conduction mode left untouched by this block
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) dac_out <= '0;
        else if (state_q == RORRT_RUN || state_q == RORRT_OFF_DLY) dac_out <= vset_in;
        else if (state_q == RORRT_RAMP && !ramp_done)
            dac_out <= DAC_W'((48'(vset_in) * 48'(ramp_ms - elapsed)) / 48'(ramp_ms));
        else dac_out <= '0;
    end
    assign stage_tristate_out = (state_q == RORRT_DECAY) || (state_q == RORRT_HOLD)
        || (state_q == RORRT_RETRY);
    assign run_pin_oe_out = (state_q == RORRT_HOLD);
    assign run_pin_out = 1'b0;

    // ==========================================
    // status, set wins over clear on write to status
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) st_q <= '0;
        else begin
            if (cmd_wr_in && cmd_code_in == CMD_STATUS) st_q <= st_q & ~cmd_data_in[4:0];
            if (in_ov_in) begin
                st_q[ST_NONE_ABOVE] <= 1'b1;
                st_q[ST_INPUT] <= 1'b1;
                st_q[ST_IN_OV] <= 1'b1;
            end
            if (state_q == RORRT_DECAY && cfg_q[CFG_DECAY_CHECK] && warn_q[10:0] != 11'h0 && !is_off
                && elapsed > lin_ms(warn_q)) st_q[ST_OFF_WARN] <= 1'b1;
            if (cmd_wr_in && bad_byte && (cmd_code_in == CMD_OUT_OV || cmd_code_in == CMD_OUT_UV
                || cmd_code_in == CMD_IN_OV || cmd_code_in == CMD_RISE_TO)) st_q[ST_COMM] <= 1'b1;
        end
    end
    assign status_out = st_q;
    assign alert_out = (|st_q) && !alert_mask_in;

    // ==========================================
    // checks
    hold_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        run_prev_q && !run_sync_q[1] && state_q == RORRT_RUN && !retry_fault
        |=> run_pin_oe_out) else $error("run not held low");
    in_ov_stat_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        in_ov_in |=> st_q[ST_IN_OV] && st_q[ST_INPUT]) else $error("in ov status");
    alert_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        in_ov_in && !alert_mask_in ##1 !alert_mask_in |-> alert_out) else $error("no alert");
    bad_byte_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cmd_wr_in && cmd_code_in == CMD_OUT_OV && bad_byte |=> $stable(out_ov_q))
        else $error("bad byte stored");
    comm_flag_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        cmd_wr_in && cmd_code_in == CMD_OUT_UV && bad_byte |=> st_q[ST_COMM])
        else $error("no comm fault");
    ramp_tri_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_q == RORRT_DECAY |-> dac_out == '0 && stage_tristate_out) else $error("tristate");
    retry_go_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_q == RORRT_RUN && retry_fault |=> state_q == RORRT_RETRY) else $error("retry");
    hold_decay_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        state_q == RORRT_HOLD && cfg_q[CFG_DECAY_CHECK] && !is_off |=> !start_out)
        else $error("early start");
    cov_hold_c: cover property (@(posedge clk_in) state_q == RORRT_HOLD ##1 start_out);
    cov_ramp_c: cover property (@(posedge clk_in) state_q == RORRT_RAMP ##1 state_q == RORRT_DECAY);
    cov_retry_c: cover property (@(posedge clk_in) state_q == RORRT_RETRY ##1 state_q == RORRT_RUN);
endmodule : rorrt_core
`default_nettype wire

// file: testbench/rorrt_host.sv
// rorrt_host: behavioural host issuing command writes and reads
// assumes the block takes a write on the edge that sees cmd_wr high
`timescale 1ns/1ps
`default_nettype none
module rorrt_host (
    input wire logic clk_in, // core clock
    output logic cmd_wr_out, // write strobe
    output logic cmd_word_out, // two-byte write
    output logic [7:0] cmd_code_out, // command code
    output logic [15:0] cmd_data_out, // write data
    input wire logic [15:0] cmd_rdata_in // read data
);
    // ==========================================
    // idle bus
    initial begin
        cmd_wr_out = 1'b0;
        cmd_word_out = 1'b0;
        cmd_code_out = 8'h00;
        cmd_data_out = 16'h0000;
    end
    // one write, strobe held for one edge
    task automatic write(input logic [7:0] code, input logic [15:0] data, input logic word);
        @(posedge clk_in);
        cmd_wr_out <= 1'b1;
        cmd_word_out <= word;
        cmd_code_out <= code;
        cmd_data_out <= data;
        @(posedge clk_in);
        cmd_wr_out <= 1'b0;
        cmd_data_out <= ~data; // released data does not hold its value
    endtask : write
    // read: code set, data taken at the next edge
    task automatic read(input logic [7:0] code, output logic [15:0] data);
        @(posedge clk_in);
        cmd_code_out <= code;
        @(posedge clk_in);
        data = cmd_rdata_in;
    endtask : read
endmodule : rorrt_host
`default_nettype wire

// file: testbench/rorrt_tb.sv
// rorrt_tb: self-checking bench for the off ramp, restart and retry block
// assumes the host model and one 100 MHz clock; 1 ms shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none
module rorrt_tb;
    import rorrt_pkg::*;
    // ==========================================
    // signals
    localparam int CMS = 10; // cycles per ms
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic cmd_wr, cmd_word;
    logic [7:0] cmd_code;
    logic [15:0] cmd_data, cmd_rdata, rd;
    logic stop_in = 1'b0, fault_in = 1'b0, in_ov_in = 1'b0, alert_mask_in = 1'b0, run_drv = 1'b1;
    logic [15:0] off_delay_in = 16'h000a; // 10 ms
    logic [DAC_W-1:0] vset_in = 12'h320, vmeas_in = 12'h320; // 800 counts
    logic run_pin_oe_out, run_pin_out, start_out, stage_tristate_out, alert_out;
    logic [DAC_W-1:0] dac_out;
    logic [4:0] status_out;
    logic [7:0] ov_act_out, uv_act_out, rise_act_out;
    int error_cnt = 0, n_checks = 0;
    wire logic run_pin = run_pin_oe_out ? run_pin_out : run_drv; // pulled up when free
    // ==========================================
    // instances and clock
    rorrt_core #(.CYC_MS(CMS)) u_rorrt_core (.clk_in(clk_in), .resetn_in(resetn_in),
        .cmd_wr_in(cmd_wr), .cmd_word_in(cmd_word), .cmd_code_in(cmd_code), .cmd_data_in(cmd_data),
        .cmd_rdata_out(cmd_rdata), .stop_in(stop_in), .off_delay_in(off_delay_in), .fault_in(fault_in),
        .in_ov_in(in_ov_in), .alert_mask_in(alert_mask_in), .vset_in(vset_in), .vmeas_in(vmeas_in),
        .run_pin_in(run_pin), .run_pin_oe_out(run_pin_oe_out), .run_pin_out(run_pin_out),
        .start_out(start_out), .dac_out(dac_out), .stage_tristate_out(stage_tristate_out),
        .alert_out(alert_out), .status_out(status_out), .ov_act_out(ov_act_out),
        .uv_act_out(uv_act_out), .rise_act_out(rise_act_out));
    rorrt_host u_rorrt_host (.clk_in(clk_in), .cmd_wr_out(cmd_wr), .cmd_word_out(cmd_word),
        .cmd_code_out(cmd_code), .cmd_data_out(cmd_data), .cmd_rdata_in(cmd_rdata));
    always #5 clk_in = ~clk_in; // 100 MHz
    // ==========================================
    // helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // watched flag: start, three-state or decay warning
    function automatic logic sig(input int k);
        case (k)
            0: return start_out;
            1: return stage_tristate_out;
            default: return status_out[ST_OFF_WARN];
        endcase
    endfunction : sig
    // count cycles until a flag is seen, bounded
    task automatic wait_sig(input int k, input int lim, output int n);
        n = 0;
        while (sig(k) !== 1'b1 && n < lim) begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask : wait_sig
    // run-pin restart (k=0) or fault retry (k=1); output falls to 99 at drop
    task automatic seq_case(input int k, input logic [15:0] cfg, input logic [DAC_W-1:0] vm,
                            input int drop, input int lo, input int hi);
        int n;
        u_rorrt_host.write(CMD_CHAN_CFG, cfg, 1'b0);
        vmeas_in <= vm;
        @(posedge clk_in);
        if (k == 0) run_drv <= 1'b0;
        else fault_in <= 1'b1;
        fork
            begin
                @(posedge clk_in);
                fault_in <= 1'b0;
                repeat (4) @(posedge clk_in);
                run_drv <= 1'b1;
                #1 if (k == 0) chk("run pin held low", 16'h2, {14'h0, run_pin_oe_out, run_pin});
                repeat (drop - 5) @(posedge clk_in);
                vmeas_in <= 12'h063;
            end
        join_none
        wait_sig(0, hi, n);
        wait fork;
        chk("start delay", 16'h1, {15'h0, n >= lo && n <= hi});
    endtask : seq_case
    // stop, ramp, then decay watch under warning limit lim
    task automatic stop_case(input logic [15:0] lim, input int lo, input int hi);
        int n;
        logic [DAC_W-1:0] d0;
        u_rorrt_host.write(CMD_OFF_WARN, lim, 1'b1);
        u_rorrt_host.write(CMD_CHAN_CFG, 16'h0002, 1'b0);
        u_rorrt_host.write(CMD_STATUS, 16'h001f, 1'b0);
        vmeas_in <= vset_in;
        d0 = dac_out;
        @(posedge clk_in);
        stop_in <= 1'b1;
        repeat (90) @(posedge clk_in);
        #1 chk("dac in off delay", {4'h0, d0}, {4'h0, dac_out});
        wait_sig(1, 30000, n);
        chk("dac at three-state", 16'h0, {4'h0, dac_out});
        chk("short ramp stretched", 16'h1, {15'h0, n >= 15 && n <= 20});
        wait_sig(2, hi, n);
        chk("decay warning", 16'h1, {15'h0, n >= lo && n <= hi});
        @(posedge clk_in);
        stop_in <= 1'b0;
    endtask : stop_case
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // ==========================================
    // main sequence
    initial begin
        logic [7:0] codes [6] = '{8'h41, 8'h45, 8'h56, 8'h63, 8'hdb, 8'hdc};
        logic [15:0] dflt [6] = '{16'h7a, 16'hb8, 16'hb8, 16'hb8, 16'hf3e8, 16'hfa58};
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            u_rorrt_host.read(codes[i], rd);
            chk("register default", dflt[i], rd);
        end
        u_rorrt_host.write(8'h41, 16'h0080, 1'b0);
        #1 chk("ov action", 16'h0080, {8'h0, ov_act_out});
        u_rorrt_host.write(8'h45, 16'h00c0, 1'b0);
        u_rorrt_host.write(8'h63, 16'h0040, 1'b1);
        #1 chk("bad byte dropped", 16'h00b8, {8'h0, uv_act_out});
        chk("word on byte dropped", 16'h00b8, {8'h0, rise_act_out});
        chk("comm fault", 16'h1, {15'h0, status_out[ST_COMM]});
        u_rorrt_host.write(8'h63, 16'h0040, 1'b0);
        #1 chk("rise action", 16'h0040, {8'h0, rise_act_out});
        u_rorrt_host.write(8'hdc, 16'h0098, 1'b1);
        u_rorrt_host.write(8'hdb, 16'h0078, 1'b1);
        u_rorrt_host.write(CMD_OFF_RAMP, 16'h8000, 1'b1);
        u_rorrt_host.read(8'hdc, rd);
        chk("hold readback", 16'h0098, rd);
        u_rorrt_host.write(CMD_STATUS, 16'h001f, 1'b0);
        #1 chk("status cleared", 16'h0, {11'h0, status_out});
        @(posedge clk_in);
        in_ov_in <= 1'b1;
        @(posedge clk_in);
        in_ov_in <= 1'b0;
        #1 chk("input ov status", 16'h7, {11'h0, status_out});
        chk("alert raised", 16'h1, {15'h0, alert_out});
        @(posedge clk_in);
        alert_mask_in <= 1'b1;
        #1 chk("alert masked", 16'h0, {15'h0, alert_out});
        u_rorrt_host.write(8'h41, 16'h00b8, 1'b0);
        seq_case(0, 16'h0, 12'h320, 1545, 1520, 1545);
        seq_case(0, 16'h2, 12'h320, 2000, 2000, 2030);
        seq_case(1, 16'h1, 12'h320, 1230, 1200, 1230);
        seq_case(1, 16'h0, 12'h064, 1600, 1600, 1630);
        stop_case(16'h0078, 1190, 1215);
        stop_case(16'h0000, 1500, 1500);
        u_rorrt_host.write(8'h41, 16'h0080, 1'b0);
        seq_case(1, 16'h1, 12'h320, 1500, 1500, 1500);
        finish_test();
    end
    // watchdog against a hang
    initial begin
        #900000;
        error_cnt++;
        finish_test();
    end
endmodule : rorrt_tb
`default_nettype wire
